// ===== design/rx_err_params.svh
/*
 * Constants of the receive error flag block: register offsets, bit
 * positions and reset values.
 * Assumes it is included by bare name from each design file that
 * needs it; it holds definitions only.
 */
`ifndef RX_ERR_PARAMS_SVH
`define RX_ERR_PARAMS_SVH

// Register offsets on the plain register port
`define RXE_ADDR_CMD      3'h0
`define RXE_ADDR_STATUS   3'h1
`define RXE_ADDR_IRQ_STAT 3'h2
`define RXE_ADDR_IRQ_MASK 3'h3
`define RXE_ADDR_DATA     3'h4

// Command register bits
`define RXE_CMD_TXEN_BIT   0
`define RXE_CMD_RXEN_BIT   2
`define RXE_CMD_ERRCLR_BIT 4
`define RXE_CMD_SYNC_BIT   6
`define RXE_CMD_STORE_MASK 8'h45
`define RXE_CMD_RESET      8'h00

// Status register bits
`define RXE_STAT_FULL_BIT  1
`define RXE_STAT_PE_BIT    3
`define RXE_STAT_OE_BIT    4
`define RXE_STAT_FE_BIT    5

// Interrupt status and mask bits
`define RXE_IRQ_PE_BIT     0
`define RXE_IRQ_OE_BIT     1
`define RXE_IRQ_FE_BIT     2
`define RXE_IRQ_RDY_BIT    3
`define RXE_IRQ_MASK_RESET 4'h0

`endif

// ===== design/rx_err_pkg.sv
/*
 * Types of the receive error flag block: state records of both
 * modules and the stop bit sampler states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rx_err_pkg;

    // Stop bit sampler states
    typedef enum logic [1:0] {
        SAMP_IDLE,
        SAMP_ARMED
    } samp_state_type;

    // Whole state of the stop bit sampler
    typedef struct packed {
        samp_state_type state;
        logic           hit;
    } samp_regs_type;

    // Whole state of the flag block
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
        logic       data_full;
        logic       parity_err;
        logic       overrun;
        logic       framing;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [7:0] rdata;
    } flag_regs_type;

endpackage

// ===== design/stop_sampler.sv
/*
 * Stop bit sampler: looks at the line only at the first stop bit
 * midpoint after each start bit and reports a framing fault.
 * Assumes the bit timing logic pulses frame_start and stop_mid.
 */
`include "rx_err_params.svh"

module stop_sampler (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic async_mode,
    input  wire logic frame_start,
    input  wire logic stop_mid,
    input  wire logic rx_level,
    output logic      framing_hit
);

    rx_err_pkg::samp_regs_type st_r;   // Registered state
    rx_err_pkg::samp_regs_type st_nxt; // Next state

    // Arm on start, check once, then ignore further stop bits
    always_comb begin
        st_nxt     = st_r;
        st_nxt.hit = 1'b0;
        case (st_r.state)
            rx_err_pkg::SAMP_IDLE: begin
                // Later stop bits land here and are not looked at
                if (frame_start) begin
                    st_nxt.state = rx_err_pkg::SAMP_ARMED;
                end
            end
            rx_err_pkg::SAMP_ARMED: begin
                if (stop_mid) begin
                    // Zero at first stop midpoint, async only
                    st_nxt.hit   = async_mode && !rx_level;
                    st_nxt.state = rx_err_pkg::SAMP_IDLE;
                end
            end
            default: begin
                st_nxt.state = rx_err_pkg::SAMP_IDLE;
            end
        endcase
    end

    // State register, frozen while ce is low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign framing_hit = st_r.hit;

    chk_first_stop_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && st_r.state == rx_err_pkg::SAMP_ARMED && stop_mid
            && async_mode && !rx_level |=> framing_hit)
        else $error("framing hit missing on zero stop bit");

    chk_later_stops_ignored: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && st_r.state == rx_err_pkg::SAMP_IDLE |=> !framing_hit)
        else $error("framing hit outside first stop bit");

endmodule

// ===== design/usart_receive_error_flags.sv
/*
 * Receive error flags of the serial unit: parity, overrun and
 * framing flags, command and status registers, received data
 * holding register and a level interrupt.
 * Assumes the receiver's shift logic pulses char_done with the
 * character and its parity result, and frame timing pulses for the
 * stop bit sampler; all inputs are synchronous to core_clk.
 */
`include "rx_err_params.svh"

module usart_receive_error_flags (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       char_done,
    input  wire logic [7:0] char_data,
    input  wire logic       parity_bad,
    input  wire logic       hunt_active,
    input  wire logic       frame_start,
    input  wire logic       stop_mid,
    input  wire logic       rx_level,
    output logic            rx_enable,
    output logic            parity_error_flag,
    output logic            overrun_flag,
    output logic            framing_flag,
    output logic            irq
);

    // Sticky bit update; the set beats a clear in the same cycle
    function automatic logic sticky(
        input logic old_val,
        input logic set_val,
        input logic clr_val
    );
        sticky = (old_val && !clr_val) || set_val;
    endfunction

    // Same rule applied across a vector of bits
    function automatic logic [3:0] sticky_vec(
        input logic [3:0] old_val,
        input logic [3:0] set_val,
        input logic [3:0] clr_val
    );
        sticky_vec = (old_val & ~clr_val) | set_val;
    endfunction

    rx_err_pkg::flag_regs_type st_r;   // Registered state
    rx_err_pkg::flag_regs_type st_nxt; // Next state

    logic frame_hit;   // Framing fault pulse from the sampler
    logic sync_mode;   // Synchronous mode selected
    logic cmd_wr;      // Command register write
    logic clr_err;     // Error-clear command
    logic rx_off_cmd;  // Receive-disable command
    logic data_rd;     // Data register read
    logic parity_set;  // Parity fault this cycle
    logic overrun_set; // Overrun this cycle
    logic char_load;   // Character taken into the holding register
    logic [3:0] irq_set; // Interrupt events this cycle
    logic [3:0] irq_clr; // Write-one-to-clear mask

    // Stop bit check runs in its own small machine
    stop_sampler u_stop_sampler (
        .core_clk    (core_clk),
        .rst         (rst),
        .ce          (ce),
        .async_mode  (!sync_mode),
        .frame_start (frame_start),
        .stop_mid    (stop_mid),
        .rx_level    (rx_level),
        .framing_hit (frame_hit)
    );

    // Mode and enable come straight from the command register
    assign sync_mode = st_r.cmd[`RXE_CMD_SYNC_BIT];
    assign rx_enable = st_r.cmd[`RXE_CMD_RXEN_BIT];

    // Register port decode
    always_comb begin
        cmd_wr     = wr && (addr == `RXE_ADDR_CMD);
        // Error-clear is a command, not a stored bit
        clr_err    = cmd_wr && wdata[`RXE_CMD_ERRCLR_BIT];
        // Any command write leaving receive off counts as disable
        rx_off_cmd = cmd_wr && !wdata[`RXE_CMD_RXEN_BIT];
        data_rd    = rd && (addr == `RXE_ADDR_DATA);
        irq_clr    = 4'h0;
        if (wr && (addr == `RXE_ADDR_IRQ_STAT)) begin
            irq_clr = wdata[3:0];
        end
    end

    // Receive events
    always_comb begin
        // Parity is judged with receive on or off
        // but never while hunting for sync characters
        parity_set  = char_done && parity_bad
                      && !(sync_mode && hunt_active);
        // Character accepted only while receiving is enabled
        char_load   = char_done && rx_enable;
        // A read in the same cycle empties the old one in time
        overrun_set = char_load && st_r.data_full && !data_rd;
        irq_set = 4'h0;
        irq_set[`RXE_IRQ_PE_BIT]  = parity_set;
        irq_set[`RXE_IRQ_OE_BIT]  = overrun_set;
        irq_set[`RXE_IRQ_FE_BIT]  = frame_hit;
        irq_set[`RXE_IRQ_RDY_BIT] = char_load;
    end

    // Next state of every register
    always_comb begin
        st_nxt = st_r;

        // Command register keeps only its stored bits
        if (cmd_wr) begin
            st_nxt.cmd = wdata & `RXE_CMD_STORE_MASK;
        end

        // Holding register; a new character wins over a read
        if (char_load) begin
            st_nxt.data      = char_data;
            st_nxt.data_full = 1'b1;
        end else if (data_rd) begin
            st_nxt.data_full = 1'b0;
        end

        // Error flags hold until their own clears
        st_nxt.parity_err = sticky(st_r.parity_err, parity_set,
                                   clr_err);
        st_nxt.overrun    = sticky(st_r.overrun, overrun_set,
                                   clr_err || rx_off_cmd);
        st_nxt.framing    = sticky(st_r.framing, frame_hit,
                                   clr_err);

        // Interrupt status, cleared by writing ones
        st_nxt.irq_stat = sticky_vec(st_r.irq_stat, irq_set, irq_clr);

        // Interrupt mask
        if (wr && (addr == `RXE_ADDR_IRQ_MASK)) begin
            st_nxt.irq_mask = wdata[3:0];
        end

        // Read data stand only in the cycle after the strobe
        st_nxt.rdata = 8'h00;
        if (rd) begin
            case (addr)
                `RXE_ADDR_CMD: begin
                    st_nxt.rdata = st_r.cmd;
                end
                `RXE_ADDR_STATUS: begin
                    st_nxt.rdata[`RXE_STAT_FULL_BIT] = st_r.data_full;
                    st_nxt.rdata[`RXE_STAT_PE_BIT]   = st_r.parity_err;
                    st_nxt.rdata[`RXE_STAT_OE_BIT]   = st_r.overrun;
                    st_nxt.rdata[`RXE_STAT_FE_BIT]   = st_r.framing;
                end
                `RXE_ADDR_IRQ_STAT: begin
                    st_nxt.rdata = {4'h0, st_r.irq_stat};
                end
                `RXE_ADDR_IRQ_MASK: begin
                    st_nxt.rdata = {4'h0, st_r.irq_mask};
                end
                `RXE_ADDR_DATA: begin
                    st_nxt.rdata = st_r.data;
                end
                default: begin
                    // Unmapped reads return zero
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops, irq is a level
    assign rdata             = st_r.rdata;
    assign parity_error_flag = st_r.parity_err;
    assign overrun_flag      = st_r.overrun;
    assign framing_flag      = st_r.framing;
    assign irq               = |(st_r.irq_stat & st_r.irq_mask);

    // Checks on what this block drives; all but the reset check are
    // held off while rst is high, so reset values are never judged
    chk_parity_sets: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && char_done && parity_bad && !(sync_mode && hunt_active)
        |=> parity_error_flag)
        else $error("parity flag not set on bad character");

    chk_parity_rx_off: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && !rx_enable && !sync_mode && char_done && parity_bad
        |=> parity_error_flag ##1 (parity_error_flag || $past(clr_err)))
        else $error("parity flag ignored with receive off");

    chk_parity_hunt: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && !parity_error_flag && sync_mode && hunt_active
        |=> !parity_error_flag)
        else $error("parity flag changed while hunting");

    chk_parity_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && clr_err && !(char_done && parity_bad)
        |=> !parity_error_flag)
        else $error("parity flag not cleared");

    chk_overrun_sets: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && char_done && rx_enable && st_r.data_full && !data_rd
        |=> overrun_flag && st_r.data == $past(char_data))
        else $error("overrun not flagged");

    chk_overrun_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && (clr_err || rx_off_cmd) && !overrun_set
        |=> !overrun_flag)
        else $error("overrun not cleared by command");

    chk_framing_sets: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && frame_hit |=> framing_flag)
        else $error("framing flag not set");

    chk_framing_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && clr_err && !frame_hit |=> !framing_flag)
        else $error("framing flag not cleared");

    chk_flags_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        parity_error_flag && !(ce && clr_err) |=> parity_error_flag)
        else $error("parity flag dropped without a clear");

    chk_frozen_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        !ce [*2] |-> $stable(overrun_flag) && $stable(framing_flag)
            && $stable(parity_error_flag) && $stable(irq))
        else $error("flags moved while clock enable low");

    // Framing flag holds until an error-clear
    chk_framing_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        framing_flag && !(ce && clr_err)
        |=> framing_flag)
        else $error("framing flag dropped without a clear");

    // Overrun holds until error-clear or receive-disable
    chk_overrun_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        overrun_flag && !(ce && (clr_err || rx_off_cmd))
        |=> overrun_flag)
        else $error("overrun dropped without a clear");

    // No parity flag without a bad character
    chk_parity_cause: assert property (
        @(posedge core_clk) disable iff (rst)
        !parity_error_flag && !(ce && char_done && parity_bad)
        |=> !parity_error_flag)
        else $error("parity flag set without a bad character");

    // Overrun needs an enabled receiver and an unread character
    chk_overrun_cause: assert property (
        @(posedge core_clk) disable iff (rst)
        !overrun_flag && !(ce && char_done && rx_enable
            && st_r.data_full && !data_rd)
        |=> !overrun_flag)
        else $error("overrun set without a lost character");

    // Receive off never raises overrun, whatever arrives
    chk_overrun_rx_off: assert property (
        @(posedge core_clk) disable iff (rst)
        !overrun_flag && !rx_enable
        |=> !overrun_flag)
        else $error("overrun set with receive off");

    // Framing flag only from the sampler's pulse
    chk_framing_cause: assert property (
        @(posedge core_clk) disable iff (rst)
        !framing_flag && !(ce && frame_hit)
        |=> !framing_flag)
        else $error("framing flag set without a zero stop bit");

    // Synchronous mode never reports a framing fault
    chk_sync_no_frame: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && sync_mode |=> !frame_hit)
        else $error("framing fault reported in sync mode");

    // Error-clear acts once and is never stored
    chk_clear_not_kept: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && cmd_wr |=> !st_r.cmd[`RXE_CMD_ERRCLR_BIT])
        else $error("error-clear bit kept in command register");

    // Receive enable follows every command write
    chk_rx_enable_cmd: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && cmd_wr
        |=> rx_enable == $past(wdata[`RXE_CMD_RXEN_BIT]))
        else $error("receive enable not taken from command");

    // Status read shows the flags of the strobe cycle
    chk_status_read: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && rd && addr == `RXE_ADDR_STATUS
        |=> rdata[`RXE_STAT_PE_BIT] == $past(parity_error_flag)
            && rdata[`RXE_STAT_FE_BIT] == $past(framing_flag))
        else $error("status read does not match the flags");

    // Read data stand for one cycle only, zero otherwise
    chk_rdata_idle: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && !rd |=> rdata == 8'h00)
        else $error("read data outside the read slot");

    // Characters refused with receive off leave the data alone
    chk_rx_off_no_load: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && char_done && !rx_enable
        |=> $stable(st_r.data))
        else $error("character taken with receive off");

    // Reset leaves every flag, the interrupt and read data low
    chk_reset_quiet: assert property (
        @(posedge core_clk)
        rst |=> !parity_error_flag && !overrun_flag
            && !framing_flag && !irq && rdata == 8'h00)
        else $error("flags not cleared by reset");

    // A masked-in framing fault raises the interrupt
    chk_irq_framing: assert property (
        @(posedge core_clk) disable iff (rst)
        ce && frame_hit && st_r.irq_mask[`RXE_IRQ_FE_BIT]
            && !(wr && addr == `RXE_ADDR_IRQ_MASK)
        |=> irq)
        else $error("interrupt missing on framing fault");

endmodule

// ===== tb/rx_line_sender.sv
/*
 * Model of the remote transmitter on the receive line: finished
 * characters with their parity result, and frame timing pulses.
 * Assumes one clock shared with the block; the bench calls its tasks.
 */
module rx_line_sender (
    input  wire logic       core_clk,
    output logic            char_done,
    output logic      [7:0] char_data,
    output logic            parity_bad,
    output logic            frame_start,
    output logic            stop_mid,
    output logic            rx_level
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet line sits at the mark level
    initial begin
        char_done   = 1'b0;
        char_data   = 8'h00;
        parity_bad  = 1'b0;
        frame_start = 1'b0;
        stop_mid    = 1'b0;
        rx_level    = 1'b1;
    end

    // One finished character, strobe one cycle long
    task automatic send_char(input logic [7:0] value, input logic bad);
        @(posedge core_clk);
        char_done  <= 1'b1;
        char_data  <= value;
        parity_bad <= bad;
        @(posedge core_clk);
        char_done  <= 1'b0;
        // Stale data must not look valid, so show its inverse
        char_data  <= ~value;
        parity_bad <= ~bad;
    endtask

    // Frame with two stop bits; only the first one may count
    task automatic send_frame(input logic stop1, input logic stop2);
        @(posedge core_clk);
        frame_start <= 1'b1;
        rx_level    <= 1'b0;
        @(posedge core_clk);
        frame_start <= 1'b0;
        // Data bits toggle so the line never looks settled
        repeat (3) begin
            @(posedge core_clk);
            rx_level <= ~rx_level;
        end
        @(posedge core_clk);
        stop_mid <= 1'b1;
        rx_level <= stop1;
        @(posedge core_clk);
        stop_mid <= 1'b0;
        @(posedge core_clk);
        stop_mid <= 1'b1;
        rx_level <= stop2;
        @(posedge core_clk);
        stop_mid <= 1'b0;
        rx_level <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

// ===== tb/testbench.sv
/*
 * Self-checking bench of the receive error flags: register tasks,
 * a line sender model and flag checks after each event.
 * Assumes the design files and the sender model are compiled first.
 */
`include "rx_err_params.svh"

`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       core_clk;     // 200 MHz system clock
    logic       rst;          // Synchronous reset
    logic       ce;           // Clock enable of the design
    logic       wr;           // Register write strobe
    logic       rd;           // Register read strobe
    logic       hunt_active;  // Sync hunt in progress
    logic [2:0] addr;         // Register address
    logic [7:0] wdata;        // Register write data
    logic [7:0] rdata;        // Register read data
    logic       char_done;    // From the sender model
    logic [7:0] char_data;
    logic       parity_bad;
    logic       frame_start;
    logic       stop_mid;
    logic       rx_level;
    logic       rx_enable;    // Design outputs
    logic       parity_error_flag;
    logic       overrun_flag;
    logic       framing_flag;
    logic       irq;
    int         errors;       // Mismatch count
    int         total_checks; // Comparison count

    // Design under test, clock enable driven by the bench
    usart_receive_error_flags i_dut (
        .core_clk(core_clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .char_done(char_done), .char_data(char_data),
        .parity_bad(parity_bad), .hunt_active(hunt_active),
        .frame_start(frame_start), .stop_mid(stop_mid),
        .rx_level(rx_level), .rx_enable(rx_enable),
        .parity_error_flag(parity_error_flag),
        .overrun_flag(overrun_flag), .framing_flag(framing_flag),
        .irq(irq)
    );

    rx_line_sender i_sender (
        .core_clk(core_clk), .char_done(char_done),
        .char_data(char_data), .parity_bad(parity_bad),
        .frame_start(frame_start), .stop_mid(stop_mid),
        .rx_level(rx_level)
    );

    // Free running clock
    always #2.5 core_clk = ~core_clk;

    // One-cycle write, then let its effect land
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask

    // One-cycle read; data stand only in the following cycle
    task automatic expect_rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        `CHECK(rdata, e)
    endtask

    // All three flags at once, after the last edge settles
    task automatic flags(input logic pe, input logic ov, input logic fe);
        #1;
        `CHECK(parity_error_flag, pe)
        `CHECK(overrun_flag, ov)
        `CHECK(framing_flag, fe)
    endtask

    // Verdict and end of run
    task automatic stop_test;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        hunt_active = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        errors = 0;
        total_checks = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        flags(1'b0, 1'b0, 1'b0);
        `CHECK(irq, 1'b0)
        expect_rd(`RXE_ADDR_STATUS, 8'h00);
        expect_rd(3'h5, 8'h00);
        // Clock enable low: a bad character is not taken
        @(posedge core_clk);
        ce <= 1'b0;
        i_sender.send_char(8'h77, 1'b1);
        flags(1'b0, 1'b0, 1'b0);
        @(posedge core_clk);
        ce <= 1'b1;
        // Receiver disabled: parity still tracked, no overrun
        i_sender.send_char(8'h5a, 1'b1);
        flags(1'b1, 1'b0, 1'b0);
        repeat (5) @(posedge core_clk);
        flags(1'b1, 1'b0, 1'b0);
        expect_rd(`RXE_ADDR_STATUS, 8'h01 << `RXE_STAT_PE_BIT);
        expect_rd(`RXE_ADDR_IRQ_STAT, 8'h01 << `RXE_IRQ_PE_BIT);
        `CHECK(irq, 1'b0)
        reg_wr(`RXE_ADDR_IRQ_MASK, 8'h01);
        `CHECK(irq, 1'b1)
        reg_wr(`RXE_ADDR_IRQ_STAT, 8'h01);
        `CHECK(irq, 1'b0)
        reg_wr(`RXE_ADDR_IRQ_MASK, 8'h00);
        reg_wr(`RXE_ADDR_CMD, 8'h10);
        flags(1'b0, 1'b0, 1'b0);
        expect_rd(`RXE_ADDR_CMD, 8'h00);
        // Sync mode: hunting skips the parity check
        reg_wr(`RXE_ADDR_CMD, 8'h44);
        hunt_active <= 1'b1;
        i_sender.send_char(8'h11, 1'b1);
        flags(1'b0, 1'b0, 1'b0);
        hunt_active <= 1'b0;
        i_sender.send_char(8'h22, 1'b1);
        flags(1'b1, 1'b1, 1'b0);
        reg_wr(`RXE_ADDR_CMD, 8'h00);
        flags(1'b1, 1'b0, 1'b0);
        `CHECK(rx_enable, 1'b0)
        reg_wr(`RXE_ADDR_CMD, 8'h10);
        flags(1'b0, 1'b0, 1'b0);
        expect_rd(`RXE_ADDR_DATA, 8'h22);
        // Async, enabled: overrun on unread character
        reg_wr(`RXE_ADDR_CMD, 8'h04);
        `CHECK(rx_enable, 1'b1)
        i_sender.send_char(8'ha5, 1'b0);
        expect_rd(`RXE_ADDR_DATA, 8'ha5);
        flags(1'b0, 1'b0, 1'b0);
        i_sender.send_char(8'h3c, 1'b0);
        i_sender.send_char(8'hc3, 1'b0);
        flags(1'b0, 1'b1, 1'b0);
        reg_wr(`RXE_ADDR_CMD, 8'h14);
        flags(1'b0, 1'b0, 1'b0);
        expect_rd(`RXE_ADDR_DATA, 8'hc3);
        i_sender.send_char(8'h0f, 1'b0);
        i_sender.send_char(8'hf0, 1'b0);
        flags(1'b0, 1'b1, 1'b0);
        reg_wr(`RXE_ADDR_CMD, 8'h00);
        flags(1'b0, 1'b0, 1'b0);
        i_sender.send_char(8'h01, 1'b0);
        i_sender.send_char(8'h02, 1'b0);
        flags(1'b0, 1'b0, 1'b0);
        // Framing: async first stop bit only
        reg_wr(`RXE_ADDR_CMD, 8'h04);
        reg_wr(`RXE_ADDR_IRQ_STAT, 8'h0f);
        reg_wr(`RXE_ADDR_IRQ_MASK, 8'h04);
        i_sender.send_frame(1'b0, 1'b1);
        flags(1'b0, 1'b0, 1'b1);
        `CHECK(irq, 1'b1)
        expect_rd(`RXE_ADDR_STATUS, (8'h01 << `RXE_STAT_FE_BIT)
                  | (8'h01 << `RXE_STAT_FULL_BIT));
        reg_wr(`RXE_ADDR_IRQ_STAT, 8'h04);
        `CHECK(irq, 1'b0)
        reg_wr(`RXE_ADDR_CMD, 8'h14);
        flags(1'b0, 1'b0, 1'b0);
        i_sender.send_frame(1'b1, 1'b0);
        flags(1'b0, 1'b0, 1'b0);
        reg_wr(`RXE_ADDR_CMD, 8'h40);
        i_sender.send_frame(1'b0, 1'b0);
        flags(1'b0, 1'b0, 1'b0);
        stop_test();
    end
endmodule
